// ===== verilog/bvt_pkg.sv
// Package with shared constants, types and register layout for the bivalue timer block.
`default_nettype none
package bvt_pkg;
  // APB register byte offsets.
  localparam logic [7:0] BVT_MODE_OFS = 8'h00;
  localparam logic [7:0] BVT_ICR_OFS = 8'h04;
  localparam logic [7:0] BVT_CTRL_OFS = 8'h08;
  localparam logic [7:0] BVT_REG0_OFS = 8'h0C;
  localparam logic [7:0] BVT_REG1_OFS = 8'h10;
  localparam logic [7:0] BVT_CNT_OFS = 8'h14;
  localparam logic [7:0] BVT_PSC_OFS = 8'h18;
  localparam logic [7:0] BVT_STAT_OFS = 8'h1C;
  // Mode register fields.
  localparam int BVT_MODE_BIVAL_POS = 0;
  localparam int BVT_MODE_RM0_POS = 1;
  localparam int BVT_MODE_ONESHOT_POS = 2;
  localparam int BVT_MODE_CASC_POS = 3;
  // Input control register fields.
  localparam int BVT_ICR_FUNC_POS = 0;
  localparam int BVT_ICR_AEDGE_POS = 4;
  localparam int BVT_ICR_BEDGE_POS = 6;
  // Control register fields; trigger bits are write-one pulses.
  localparam int BVT_CTRL_DIR_POS = 0;
  localparam int BVT_CTRL_RUN_POS = 1;
  localparam int BVT_CTRL_CP0_POS = 2;
  // Reset values.
  localparam logic [15:0] BVT_CNT_RST = 16'h0000;
  localparam logic [7:0] BVT_PSC_RST = 8'h00;
  // The prescaler base tick divides the system clock by three.
  localparam int BVT_BASE_DIV = 3;
  // Input edge selection codes.
  localparam logic [1:0] BVT_EDGE_RISE = 2'h1;
  localparam logic [1:0] BVT_EDGE_FALL = 2'h2;
  localparam logic [1:0] BVT_EDGE_BOTH = 2'h3;
  // Input function codes.
  typedef enum logic [3:0] {
    BVT_F_NONE = 4'h0, BVT_F_BTRIG = 4'h1, BVT_F_AGATE = 4'h2, BVT_F_AGATE_BTRIG = 4'h3,
    BVT_F_BCLK = 4'h4, BVT_F_ATRIG = 4'h5, BVT_F_AGATE_BCLK = 4'h6, BVT_F_BOTHTRIG = 4'h7,
    BVT_F_UPDN_CLK = 4'h8, BVT_F_AUD_BCLK = 4'h9, BVT_F_TRIG_UPDN = 4'hA, BVT_F_AUD = 4'hB,
    BVT_F_AUTODISC = 4'hC, BVT_F_ATRIG_BCLK = 4'hD, BVT_F_ACLK_BTRIG = 4'hE, BVT_F_ATRIG_BGATE = 4'hF
  } bvt_func_e;
  // Pin events of one input after edge selection.
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
    logic hit;
  } bvt_pin_s;
endpackage : bvt_pkg
`default_nettype wire

// ===== verilog/bvt_pin_sync.sv
// Two-stage synchroniser with edge selection for one timer input.
`timescale 1ns/1ns
`default_nettype none
module bvt_pin_sync (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic pin_in,
  input wire logic [1:0] edge_sel,
  output var bvt_pkg::bvt_pin_s ev
);
  import bvt_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } bvt_sync_s;
  bvt_sync_s st_q, st_d;

  // The first stage only feeds the second; edges come from stages two and three.
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Edge qualification follows the two-bit selector; zero selects no edge.
  always_comb begin
    ev.level = st_q.s2;
    ev.rise = st_q.s2 & ~st_q.s3;
    ev.fall = ~st_q.s2 & st_q.s3;
    ev.hit = (edge_sel[0] & ev.rise) | (edge_sel[1] & ev.fall);
  end

  a_rise_hit: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ev.rise && edge_sel == BVT_EDGE_RISE) |-> ev.hit) else $error("Rising edge missed.");
  a_sync_delay: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(pin_in) ##2 1 |-> ev.level || !$past(pin_in, 1)) else $error("Sync delay wrong.");
endmodule : bvt_pin_sync
`default_nettype wire

// ===== verilog/bvt_prescaler.sv
// Cascadable prescaler: divides its input ticks by value plus one.
`timescale 1ns/1ns
`default_nettype none
module bvt_prescaler #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic tick_in,
  input wire logic [WIDTH-1:0] div_val,
  output logic tick_out
);
  import bvt_pkg::*;
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic out;
  } bvt_psc_s;
  bvt_psc_s st_q, st_d;

  // A value of zero passes every input tick through, so cascaded stages run at the same rate.
  always_comb begin
    st_d = st_q;
    st_d.out = 1'b0;
    if (tick_in) begin
      if (st_q.cnt >= div_val) begin
        st_d.cnt = '0;
        st_d.out = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick_out = st_q.out;

  a_zero_pass: assert property (@(posedge core_clk) disable iff (sys_rst)
    (tick_in && div_val == '0) |=> tick_out) else $error("Zero divide dropped tick.");
endmodule : bvt_prescaler
`default_nettype wire

// ===== verilog/bvt_timer.sv
// Bivalue timer core with input role assignment, alternating load/capture and cascade.
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
module bvt_timer #(
  parameter int PSC_W = 8,
  parameter int CNT_W = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_input_a,
  input wire logic timer_input_b,
  input wire logic cascade_tick_in,
  output logic cascade_tick_out,
  output logic [CNT_W-1:0] count_out
);
  import bvt_pkg::*;

  typedef struct packed {
    logic [3:0] mode;
    logic [7:0] icr;
    logic [1:0] ctrl;
    logic [CNT_W-1:0] reg0;
    logic [CNT_W-1:0] reg1;
    logic [CNT_W-1:0] cnt;
    logic [PSC_W-1:0] psc;
    logic [1:0] base;
    logic alt_one;
    logic stopped;
    logic up_stat;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic psc_tick;
  } bvt_state_s;
  bvt_state_s st_q, st_d;

  bvt_pin_s pa, pb;
  logic base_tick, psc_src, psc_out;

  // Each pin is synchronised and edge-qualified by its own selector.
  bvt_pin_sync u_sync_a (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in(timer_input_a),
    .edge_sel(st_q.icr[BVT_ICR_AEDGE_POS +: 2]),
    .ev(pa)
  );
  bvt_pin_sync u_sync_b (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in(timer_input_b),
    .edge_sel(st_q.icr[BVT_ICR_BEDGE_POS +: 2]),
    .ev(pb)
  );

  bvt_prescaler #(.WIDTH(PSC_W)) u_psc (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tick_in(psc_src),
    .div_val(st_q.psc),
    .tick_out(psc_out)
  );

  // Decoded roles of the two inputs.
  bvt_func_e fn;
  logic bival, rm0, oneshot, sw_up;
  logic a_trig, b_trig, a_gate, b_gate, b_clk, a_clk, a_ud;
  logic step, step_up, trig0, trig1, cap0_sw, eoc;

  // Function code decode into input roles.
  always_comb begin
    fn = bvt_func_e'(st_q.icr[BVT_ICR_FUNC_POS +: 4]);
    bival = st_q.mode[BVT_MODE_BIVAL_POS];
    rm0 = st_q.mode[BVT_MODE_RM0_POS];
    oneshot = st_q.mode[BVT_MODE_ONESHOT_POS];
    sw_up = st_q.ctrl[BVT_CTRL_DIR_POS];
    a_trig = fn inside {BVT_F_ATRIG, BVT_F_BOTHTRIG, BVT_F_ATRIG_BCLK, BVT_F_ATRIG_BGATE};
    b_trig = fn inside {BVT_F_BTRIG, BVT_F_AGATE_BTRIG, BVT_F_BOTHTRIG, BVT_F_ACLK_BTRIG};
    a_gate = fn inside {BVT_F_AGATE, BVT_F_AGATE_BTRIG, BVT_F_AGATE_BCLK};
    b_gate = fn == BVT_F_ATRIG_BGATE;
    b_clk = fn inside {BVT_F_BCLK, BVT_F_AGATE_BCLK, BVT_F_AUD_BCLK, BVT_F_ATRIG_BCLK};
    a_clk = fn == BVT_F_ACLK_BTRIG;
    a_ud = fn inside {BVT_F_AUD_BCLK, BVT_F_AUD};
  end

  // Base tick is the system clock divided by three.
  assign base_tick = (st_q.base == 2'(BVT_BASE_DIV - 1));

  // Prescaler source: cascade, external clock (optionally gated) or internal tick.
  always_comb begin
    if (st_q.mode[BVT_MODE_CASC_POS]) begin
      psc_src = cascade_tick_in;
    end else if (b_clk) begin
      psc_src = pb.hit & ~(a_gate & pa.level);
    end else if (a_clk) begin
      psc_src = pa.hit;
    end else begin
      psc_src = base_tick & ~(a_gate & pa.level) & ~(b_gate & pb.level);
    end
  end

  // Counting step and direction per function code.
  always_comb begin
    step = st_q.psc_tick;
    step_up = sw_up;
    unique case (fn)
      BVT_F_UPDN_CLK: begin
        step = pa.hit | pb.hit;
        step_up = ~pb.hit;
      end
      BVT_F_AUTODISC: begin
        step = ~pa.level & (pb.rise | pb.fall);
        step_up = pb.rise;
      end
      BVT_F_AUD_BCLK, BVT_F_AUD: begin
        step_up = pa.level;
      end
      BVT_F_TRIG_UPDN: begin
        step_up = pb.hit ? 1'b0 : (pa.hit ? 1'b1 : st_q.up_stat);
      end
      default: begin
        step_up = sw_up;
      end
    endcase
  end

  // Trigger sources: A or software on zero; B on one, blocked in bivalue.
  always_comb begin
    cap0_sw = psel & penable & pwrite & (paddr == BVT_CTRL_OFS) & pwdata[BVT_CTRL_CP0_POS];
    trig0 = cap0_sw | (a_trig & pa.hit);
    trig1 = b_trig & pb.hit & ~bival;
    eoc = step & ~st_q.stopped & (step_up ? (st_q.cnt == '1) : (st_q.cnt == '0));
  end

  // Register read mux.
  function automatic logic [31:0] rd_mux(input logic [7:0] a, input bvt_state_s s);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      BVT_MODE_OFS: r[3:0] = s.mode;
      BVT_ICR_OFS: r[7:0] = s.icr;
      BVT_CTRL_OFS: r[1:0] = s.ctrl;
      BVT_REG0_OFS: r[CNT_W-1:0] = s.reg0;
      BVT_REG1_OFS: r[CNT_W-1:0] = s.reg1;
      BVT_CNT_OFS: r[CNT_W-1:0] = s.cnt;
      BVT_PSC_OFS: r[PSC_W-1:0] = s.psc;
      BVT_STAT_OFS: r[2:0] = {s.stopped, s.up_stat, s.alt_one};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : rd_mux

  // Next state: APB slave, counter, alternating load and capture.
  always_comb begin
    st_d = st_q;
    st_d.psc_tick = psc_out;
    st_d.base = base_tick ? 2'h0 : st_q.base + 2'h1;
    st_d.up_stat = step_up;
    // Zero-wait APB: access phase completes in one cycle.
    st_d.ready = psel & ~penable;
    st_d.err = 1'b0;
    if (psel & ~penable) begin
      st_d.rdata = rd_mux(paddr, st_q);
      st_d.err = ~(paddr inside {BVT_MODE_OFS, BVT_ICR_OFS, BVT_CTRL_OFS, BVT_REG0_OFS,
        BVT_REG1_OFS, BVT_CNT_OFS, BVT_PSC_OFS, BVT_STAT_OFS});
    end
    if (psel & penable & pwrite) begin
      unique case (paddr)
        BVT_MODE_OFS: st_d.mode = pwdata[3:0];
        BVT_ICR_OFS: st_d.icr = pwdata[7:0];
        BVT_CTRL_OFS: st_d.ctrl = pwdata[1:0];
        BVT_REG0_OFS: st_d.reg0 = pwdata[CNT_W-1:0];
        BVT_REG1_OFS: st_d.reg1 = pwdata[CNT_W-1:0];
        BVT_PSC_OFS: st_d.psc = pwdata[PSC_W-1:0];
        default: st_d.err = 1'b0;
      endcase
    end
    // Counting, only while running and not stopped in one-shot.
    if (step & st_q.ctrl[BVT_CTRL_RUN_POS] & ~st_q.stopped) begin
      st_d.cnt = step_up ? st_q.cnt + 1'b1 : st_q.cnt - 1'b1;
    end
    // End of count in reload mode alternates the source when bivalue.
    if (eoc & st_q.ctrl[BVT_CTRL_RUN_POS] & ~rm0) begin
      if (oneshot) begin
        st_d.stopped = 1'b1;
      end else begin
        st_d.cnt = (bival & st_q.alt_one) ? st_q.reg1 : st_q.reg0;
        st_d.alt_one = bival & ~st_q.alt_one;
      end
    end
    // Input B always captures into register one; the bivalue mask already sits in trig1.
    if (trig1) begin
      st_d.reg1 = st_q.cnt;
    end
    // Register-zero trigger: load or capture.
    if (trig0) begin
      if (~rm0) begin
        st_d.cnt = st_q.reg0;
        st_d.alt_one = bival;
        st_d.stopped = 1'b0;
      end else if (bival & st_q.alt_one) begin
        st_d.reg1 = st_q.cnt;
        st_d.alt_one = 1'b0;
      end else begin
        st_d.reg0 = st_q.cnt;
        st_d.alt_one = bival;
      end
    end
    // Bivalue clear makes register zero current again.
    if (~bival) begin
      st_d.alt_one = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.cnt <= BVT_CNT_RST;
      st_q.psc <= BVT_PSC_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.err;
  assign cascade_tick_out = st_q.psc_tick;
  assign count_out = st_q.cnt;

  a_alt_reload: assert property (@(posedge core_clk) disable iff (sys_rst)
    (eoc && st_q.ctrl[1] && bival && !rm0 && !oneshot && !trig0 && st_q.alt_one)
    |=> count_out == $past(st_q.reg1)) else $error("Reload not from one.");
  a_trig_reload: assert property (@(posedge core_clk) disable iff (sys_rst)
    (trig0 && !rm0) |=> count_out == $past(st_q.reg0)) else $error("Trigger reload wrong.");
  a_oneshot_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    (trig0 && !rm0 && oneshot) |=> !st_q.stopped) else $error("One-shot restart failed.");
  a_cap_alt: assert property (@(posedge core_clk) disable iff (sys_rst)
    (trig0 && rm0 && bival && st_q.alt_one) |=> st_q.reg1 == $past(st_q.cnt)) else $error("Capture one wrong.");
  a_bival_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    !bival |=> !st_q.alt_one) else $error("Zero not current.");
  a_b_blocked: assert property (@(posedge core_clk) disable iff (sys_rst)
    bival |-> !trig1) else $error("Input B not ignored.");
  a_updn_prio: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fn == BVT_F_UPDN_CLK && pb.hit) |-> (step && !step_up)) else $error("B lost priority.");
  a_level_dir: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fn == BVT_F_AUD_BCLK) |-> step_up == pa.level) else $error("Level direction wrong.");
  a_gate_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (a_gate && pa.level && !st_q.mode[3]) |-> !psc_src) else $error("Gate leaked.");
  a_autodisc: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fn == BVT_F_AUTODISC && pa.level) |-> !step) else $error("Autodisc stepped high.");
  a_casc_src: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_q.mode[3] |-> psc_src == cascade_tick_in) else $error("Cascade source wrong.");
  a_idle_dir: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fn == BVT_F_NONE) |-> step_up == sw_up) else $error("Software direction ignored.");
  a_fn_trig: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fn == BVT_F_TRIG_UPDN) |-> !a_trig && !b_trig) else $error("Code 1010 triggered.");

  // Bivalue rising edge: the register-zero pointer must still be current.
  sequence s_bival_rise;
    !bival ##1 bival;
  endsequence
  // An end of count in biload mode while register zero is current.
  sequence s_alt_load;
    eoc && st_q.ctrl[1] && bival && !rm0 && !oneshot && !trig0 && !st_q.alt_one;
  endsequence

  // The first reload after bivalue rises must come from register zero.
  a_first_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_bival_rise |-> !st_q.alt_one) else $error("First reload not from zero.");

  // A reload from register zero hands the next turn to register one.
  a_alt_first: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_alt_load |=> (count_out == $past(st_q.reg0)) && st_q.alt_one) else $error("Biload turn wrong.");

  // A capture while register zero is current lands in register zero.
  a_cap_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    (trig0 && rm0 && !st_q.alt_one) |=> st_q.reg0 == $past(st_q.cnt)) else $error("Capture zero wrong.");

  // A trigger on input B stores the count in register one whatever the reload selection.
  a_b_capture: assert property (@(posedge core_clk) disable iff (sys_rst)
    trig1 |=> st_q.reg1 == $past(st_q.cnt)) else $error("Input B capture wrong.");

  // Input A trigger with capture selected and no bivalue stores into register zero.
  a_a_capture: assert property (@(posedge core_clk) disable iff (sys_rst)
    (a_trig && pa.hit && rm0 && !bival) |=> st_q.reg0 == $past(st_q.cnt)) else $error("Input A capture wrong.");

  // With no input roles, each prescaler step moves the count up by one when the software direction is up.
  a_step_count: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fn == BVT_F_NONE && step && step_up && st_q.ctrl[1] && !st_q.stopped && !eoc && !trig0)
    |=> count_out == $past(count_out) + 1'b1) else $error("Internal step wrong.");

  // An open gate on A passes every qualified edge of B to the prescaler.
  a_gate_clock: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fn == BVT_F_AGATE_BCLK && !st_q.mode[BVT_MODE_CASC_POS] && !pa.level) |-> psc_src == pb.hit)
    else $error("Gated clock lost.");

  // A high gate on B blocks the internal tick.
  a_bgate_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (b_gate && pb.level && !st_q.mode[BVT_MODE_CASC_POS]) |-> !psc_src) else $error("Gate B leaked.");

  // Edges on B clock the prescaler when B is the external clock.
  a_bclk_src: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fn == BVT_F_BCLK && !st_q.mode[BVT_MODE_CASC_POS]) |-> psc_src == pb.hit) else $error("B clock lost.");

  // Edges on A clock the prescaler when A is the external clock.
  a_aclk_src: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fn == BVT_F_ACLK_BTRIG && !st_q.mode[BVT_MODE_CASC_POS]) |-> psc_src == pa.hit) else $error("A clock lost.");

  // A trigger on B selects down counting and wins over A.
  a_trig_updn: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fn == BVT_F_TRIG_UPDN && pb.hit) |-> !step_up) else $error("Trigger down lost.");

  // A lone edge on A counts one step up.
  a_clkud_up: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fn == BVT_F_UPDN_CLK && pa.hit && !pb.hit) |-> step && step_up) else $error("Clock up lost.");

  // A rising edge on B while A is low counts one step up.
  a_autodisc_up: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fn == BVT_F_AUTODISC && !pa.level && pb.rise) |-> step && step_up) else $error("Autodisc up lost.");
endmodule : bvt_timer
`default_nettype wire

// ===== test/bvt_pin_src.sv
// Behavioural model of the two external signal sources on the timer inputs.
`timescale 1ns/1ns
`default_nettype none
module bvt_pin_src (
  input wire logic core_clk,
  output logic pin_a,
  output logic pin_b
);
  // Six clocks per level keeps every pulse, gap and gate above the minimum widths.
  localparam int HOLD = 6;

  // Both sources idle low until the bench asks for a level.
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // Levels change just after a rising edge, then stay put for the hold time.
  task automatic drive(input logic a, input logic b);
    pin_a <= a;
    pin_b <= b;
    repeat (HOLD) @(posedge core_clk);
  endtask : drive
endmodule : bvt_pin_src
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking testbench for the bivalue timer block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import bvt_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} bvt_row_s;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err_q;
  logic pin_a, pin_b, tick_in, tick_out;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [15:0] count_out, c0, r0;
  int n_mismatch, samples_checked, cyc, k;
  // Each row is written, read back and judged; the last one is unmapped.
  bvt_row_s rows [6] = '{
    '{BVT_MODE_OFS, 32'h0000000F, 32'h0000000F, 1'b0},
    '{BVT_ICR_OFS, 32'h000000FF, 32'h000000FF, 1'b0},
    '{BVT_REG0_OFS, 32'h0000ABCD, 32'h0000ABCD, 1'b0},
    '{BVT_REG1_OFS, 32'h00001234, 32'h00001234, 1'b0},
    '{BVT_PSC_OFS, 32'h0000005A, 32'h0000005A, 1'b0},
    '{8'h20, 32'hFFFFFFFF, 32'h00000000, 1'b1}};

  bvt_timer u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_input_a(pin_a), .timer_input_b(pin_b),
    .cascade_tick_in(tick_in), .cascade_tick_out(tick_out), .count_out(count_out));
  bvt_pin_src u_src (.core_clk(core_clk), .pin_a(pin_a), .pin_b(pin_b));

  // Free-running 50 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Hang guard: the sequence needs about 7300 cycles.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // An idle edge keeps a following call from assigning psel twice in one step.
    @(posedge core_clk);
  endtask : apb

  task automatic cfg(input logic [31:0] mode, input logic [31:0] icr, input logic [31:0] ctrl);
    apb(1'b1, BVT_MODE_OFS, mode);
    apb(1'b1, BVT_ICR_OFS, icr);
    apb(1'b1, BVT_CTRL_OFS, ctrl);
  endtask : cfg

  task automatic pulse(input logic [1:0] hi, input logic [1:0] lo, input int n);
    repeat (n) begin
      u_src.drive(hi[1], hi[0]);
      u_src.drive(lo[1], lo[0]);
    end
  endtask : pulse

  // Reports the finished test, parks the pins low and resets for the next one.
  task automatic next_test(input string done_name);
    $display("test %s finished", done_name);
    u_src.drive(1'b0, 1'b0);
    sys_rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
  endtask : next_test

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Main sequence: reset values, register rows, then the hand-written cases.
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    tick_in = 1'b0;
    cyc = 0;
    n_mismatch = 0;
    samples_checked = 0;
    next_test("start");
    chk(count_out, BVT_CNT_RST);
    apb(1'b0, BVT_PSC_OFS, 32'h0);
    chk(rd_q, BVT_PSC_RST);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      chk(err_q, rows[i].e);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd_q, rows[i].r);
      chk(err_q, rows[i].e);
    end
    // Clock up on A, down on B, B wins a tie; then A counts on falling edges only.
    next_test("registers");
    cfg(32'h0, 32'h58, 32'h2);
    pulse(2'b10, 2'b00, 2);
    chk(count_out, 16'h0002);
    pulse(2'b10, 2'b00, 1);
    chk(count_out, 16'h0003);
    pulse(2'b01, 2'b00, 1);
    chk(count_out, 16'h0002);
    pulse(2'b11, 2'b00, 1);
    chk(count_out, 16'h0001);
    cfg(32'h0, 32'h68, 32'h2);
    u_src.drive(1'b1, 1'b0);
    chk(count_out, 16'h0001);
    u_src.drive(1'b0, 1'b0);
    chk(count_out, 16'h0002);
    // Alternating reload stepped by B, software trigger, then one-shot triggers.
    next_test("clock up down");
    apb(1'b1, BVT_REG0_OFS, 32'h1);
    apb(1'b1, BVT_REG1_OFS, 32'h5);
    cfg(32'h1, 32'h58, 32'h2);
    pulse(2'b01, 2'b00, 1);
    chk(count_out, 16'h0001);
    pulse(2'b01, 2'b00, 2);
    chk(count_out, 16'h0005);
    apb(1'b1, BVT_CTRL_OFS, 32'h6);
    repeat (3) @(posedge core_clk);
    chk(count_out, 16'h0001);
    apb(1'b1, BVT_MODE_OFS, 32'h5);
    for (k = 0; k < 2; k++) begin
      pulse(2'b01, 2'b00, 2);
      apb(1'b1, BVT_CTRL_OFS, 32'h6);
      repeat (3) @(posedge core_clk);
      chk(count_out, 16'h0001);
    end
    // Alternating capture from A and software, and the restart after clearing bivalue.
    next_test("biload");
    apb(1'b1, BVT_PSC_OFS, 32'hFF);
    cfg(32'h3, 32'h15, 32'h3);
    repeat (1600) @(posedge core_clk);
    c0 = count_out;
    pulse(2'b10, 2'b00, 1);
    repeat (1600) @(posedge core_clk);
    apb(1'b1, BVT_CTRL_OFS, 32'h7);
    apb(1'b0, BVT_REG0_OFS, 32'h0);
    r0 = rd_q[15:0];
    chk(16'(r0 - c0) <= 16'h0001, 1'b1);
    apb(1'b0, BVT_REG1_OFS, 32'h0);
    chk(16'(rd_q[15:0] - r0) >= 16'h0002, 1'b1);
    repeat (800) @(posedge core_clk);
    apb(1'b1, BVT_CTRL_OFS, 32'h7);
    apb(1'b0, BVT_REG0_OFS, 32'h0);
    r0 = rd_q[15:0];
    apb(1'b1, BVT_MODE_OFS, 32'h2);
    apb(1'b1, BVT_MODE_OFS, 32'h3);
    repeat (800) @(posedge core_clk);
    apb(1'b1, BVT_CTRL_OFS, 32'h7);
    apb(1'b0, BVT_REG0_OFS, 32'h0);
    chk(rd_q[15:0] > r0, 1'b1);
    // B trigger captures into register one, and is ignored once bivalue is on.
    next_test("bicapture");
    apb(1'b1, BVT_PSC_OFS, 32'hFF);
    cfg(32'h0, 32'h41, 32'h3);
    apb(1'b1, BVT_REG1_OFS, 32'h1234);
    repeat (1600) @(posedge core_clk);
    pulse(2'b01, 2'b00, 1);
    apb(1'b0, BVT_REG1_OFS, 32'h0);
    chk(16'(count_out - rd_q[15:0]) <= 16'h0001, 1'b1);
    apb(1'b1, BVT_MODE_OFS, 32'h3);
    apb(1'b1, BVT_REG1_OFS, 32'h1234);
    pulse(2'b01, 2'b00, 1);
    apb(1'b0, BVT_REG1_OFS, 32'h0);
    chk(rd_q, 32'h00001234);
    // A trigger with reload selected loads the counter from register zero.
    next_test("b trigger");
    apb(1'b1, BVT_PSC_OFS, 32'hFF);
    apb(1'b1, BVT_REG0_OFS, 32'h100);
    cfg(32'h0, 32'h15, 32'h3);
    pulse(2'b10, 2'b00, 1);
    chk(16'(count_out - 16'h0100) <= 16'h0001, 1'b1);
    // A high holds the internal count; A low lets it run at one step per three clocks.
    next_test("a trigger");
    cfg(32'h0, 32'h02, 32'h3);
    u_src.drive(1'b1, 1'b0);
    c0 = count_out;
    repeat (30) @(posedge core_clk);
    chk(count_out, c0);
    u_src.drive(1'b0, 1'b0);
    c0 = count_out;
    repeat (30) @(posedge core_clk);
    chk(16'(count_out - c0), 16'h000A);
    // A level picks the direction while B clocks; the software bit says down.
    next_test("gate");
    // A high keeps B edges from the prescaler; A low lets them through.
    cfg(32'h0, 32'h46, 32'h3);
    pulse(2'b11, 2'b10, 2);
    chk(count_out, 16'h0000);
    pulse(2'b01, 2'b00, 2);
    chk(count_out, 16'h0002);
    next_test("gated clock");
    cfg(32'h0, 32'h49, 32'h2);
    u_src.drive(1'b1, 1'b0);
    pulse(2'b11, 2'b10, 2);
    chk(count_out, 16'h0002);
    u_src.drive(1'b0, 1'b0);
    pulse(2'b01, 2'b00, 1);
    chk(count_out, 16'h0001);
    // B edges step only while A is low; rising counts up, falling counts down.
    next_test("up down level");
    cfg(32'h0, 32'hCC, 32'h2);
    u_src.drive(1'b0, 1'b1);
    chk(count_out, 16'h0001);
    u_src.drive(1'b1, 1'b1);
    u_src.drive(1'b1, 1'b0);
    chk(count_out, 16'h0001);
    u_src.drive(1'b0, 1'b0);
    pulse(2'b01, 2'b00, 1);
    chk(count_out, 16'h0001);
    // Internal clock with software direction, then the cascaded prescaler input.
    next_test("autodiscrimination");
    cfg(32'h0, 32'h0, 32'h3);
    c0 = count_out;
    k = 0;
    repeat (30) begin
      @(posedge core_clk);
      k += int'(tick_out);
    end
    chk(k, 10);
    chk(16'(count_out - c0), 16'h000A);
    apb(1'b1, BVT_CTRL_OFS, 32'h2);
    c0 = count_out;
    repeat (30) @(posedge core_clk);
    chk(16'(c0 - count_out), 16'h000A);
    apb(1'b1, BVT_CTRL_OFS, 32'h3);
    apb(1'b1, BVT_MODE_OFS, 32'h8);
    repeat (4) @(posedge core_clk);
    c0 = count_out;
    repeat (5) begin
      tick_in <= 1'b1;
      @(posedge core_clk);
      tick_in <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
    chk(16'(count_out - c0), 16'h0005);
    $display("test cascade finished");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
